// File: common/ssp_pkg.sv
// Package for the serial master port: register map, field layout, reset values, timing counts.
// Assumes a 100 MHz core clock and a plain address/strobe register port.
package ssp_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_TXD = 8'h08;
	localparam logic [7:0] OFS_RXD = 8'h0C;
	localparam logic [7:0] OFS_ISTAT = 8'h10;
	localparam logic [7:0] OFS_IMASK = 8'h14;

	// Control field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_KEEP_NEW = 1;
	localparam int CTRL_LEN_LO = 2;
	localparam int CTRL_TXDMA = 4;
	localparam int CTRL_RXDMA = 5;
	localparam int CTRL_STALL = 6;
	localparam int CTRL_W = 7;
	localparam logic [6:0] CTRL_RST = 7'h40;

	// Word length codes
	localparam logic [1:0] LEN_8 = 2'h0;
	localparam logic [1:0] LEN_16 = 2'h1;
	localparam logic [1:0] LEN_32 = 2'h2;

	// Status field positions
	localparam int STAT_RX_LO = 0;
	localparam int STAT_TX_LO = 2;
	localparam int STAT_OVR = 4;
	localparam int STAT_BUSY = 5;
	localparam int STAT_HOLD = 6;

	// Interrupt bits: sticky events plus transmit room level
	localparam int EV_RX_WORD = 0;
	localparam int EV_OVERRUN = 1;
	localparam int EV_TX_DONE = 2;
	localparam int EV_W = 3;
	localparam int IRQ_TX_ROOM = 3;
	localparam logic [3:0] IMASK_RST = 4'h0;

	// Serial clock half period
	localparam int CLK_MHZ = 100;
	localparam int SCLK_HALF_NS = 80;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ) / 1000;

	localparam int FIFO_DEPTH = 2;
	localparam int WORD_W = 32;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ssp_bus_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOW,
		ST_HIGH,
		ST_HOLD
	} ssp_state_t;
endpackage

// File: logic/ssp_fifo.sv
// First-in first-out queue of flip-flops with fill indications.
// Assumes the caller never pushes into a full queue unless it pops in the same cycle or asks to overwrite.
`timescale 1ns/1ns
`default_nettype none
module ssp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic push_in,
	input wire logic overwrite_in,
	input wire logic [WIDTH-1:0] data_in,
	input wire logic pop_in,
	output logic [WIDTH-1:0] data_out,
	output logic empty_out,
	output logic full_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt, last;
	logic [CW-1:0] cnt_r, cnt_nxt;

	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign empty_out = (cnt_r == '0);
	assign full_out = (cnt_r == CNT_FULL);
	assign data_out = mem_r[rd_r];
	assign last = (wr_r == '0) ? AW'(DEPTH - 1) : wr_r - 1'b1;

	// Pointer and count update; overwrite replaces the newest entry in place
	always_comb
	begin
		mem_nxt = mem_r;
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		cnt_nxt = cnt_r;
		if (pop_in && !empty_out)
		begin
			rd_nxt = inc(rd_r);
			cnt_nxt = cnt_nxt - 1'b1;
		end
		if (push_in && overwrite_in && full_out && !pop_in)
			mem_nxt[last] = data_in;
		else if (push_in && (!full_out || pop_in))
		begin
			mem_nxt[wr_r] = data_in;
			wr_nxt = inc(wr_r);
			cnt_nxt = cnt_nxt + 1'b1;
		end
	end

	// Storage registers
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= '0;
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			mem_r <= mem_nxt;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule // ssp_fifo
`default_nettype wire

// File: logic/ssp_pin_sync.sv
// Three-stage synchroniser for a pin input with agreement filter.
// Assumes the input is asynchronous to clock_in.
`timescale 1ns/1ns
`default_nettype none
module ssp_pin_sync (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic pin_in,
	output logic level_out
);
	logic s1_r, s2_r, s3_r, lvl_r, lvl_nxt;

	// Change counts only once stages two and three agree
	always_comb
	begin
		lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			lvl_r <= 1'b0;
		end
		else
		begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign level_out = lvl_r;
endmodule // ssp_pin_sync
`default_nettype wire

// File: logic/ssp_master.sv
// Serial peripheral master port: transmit/receive queues, shifter, status and interrupt.
// Assumes a plain register port, one core clock, and a DMA engine on valid/ready ports.
// Operation
// - Stall serial clock when receive side full
// - Hold shifted word, move when space frees
// - Overrun policy: discard new or overwrite queued
// - Flag overrun when word meets full buffer
// - Clear shift register after handoff or discard
// - Report receive fill: empty, partial, full
// - Transmit fill status exact after core writes
// - Transmit interrupt from transmit queue room
// - Core and DMA transfers both kept accurate
// - Word lengths 8, 16, 32 bits
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ssp_master #(
	parameter int DEPTH = ssp_pkg::FIFO_DEPTH,
	parameter int HALF_CYC = ssp_pkg::SCLK_HALF_CYC
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire ssp_pkg::ssp_bus_t bus_in,
	output logic [31:0] rdata_out,
	input wire logic dma_tx_valid_in,
	input wire logic [31:0] dma_tx_data_in,
	output logic dma_tx_ready_out,
	output logic dma_rx_valid_out,
	output logic [31:0] dma_rx_data_out,
	input wire logic dma_rx_ready_in,
	input wire logic serial_data_in,
	output logic serial_clock_out,
	output logic serial_data_out,
	output logic select_n_out,
	output logic irq_out
);
	localparam int W = ssp_pkg::WORD_W;
	localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

	ssp_pkg::ssp_state_t st_r, st_nxt;
	logic [ssp_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [ssp_pkg::EV_W-1:0] istat_r, istat_nxt, ev;
	logic [3:0] imask_r, imask_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [W-1:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt;
	logic [5:0] bits_r, bits_nxt;
	logic [7:0] div_r, div_nxt;
	logic miso;
	logic tx_push, tx_pop, tx_empty, tx_full;
	logic rx_push, rx_pop, rx_over, rx_empty, rx_full;
	logic [W-1:0] tx_head, rx_head, tx_wdata;
	logic core_txw, core_rxr;
	logic sclk_r, sclk_nxt, sel_n_r, sel_n_nxt;

	// Bits per word for a length code
	function automatic logic [5:0] len_bits(input logic [1:0] code);
		unique case (code)
			ssp_pkg::LEN_8: len_bits = 6'h08;
			ssp_pkg::LEN_16: len_bits = 6'h10;
			ssp_pkg::LEN_32: len_bits = 6'h20;
			default: len_bits = 6'h08; // Reserved code treated as 8
		endcase
	endfunction

	// Fill field: 00 empty, 01 partial, 11 full
	function automatic logic [1:0] fill(input logic empty, input logic full);
		fill = {full, !empty};
	endfunction

	ssp_pin_sync u_sync (
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.pin_in(serial_data_in),
		.level_out(miso)
	);

	ssp_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_txq (
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.push_in(tx_push),
		.overwrite_in(1'b0),
		.data_in(tx_wdata),
		.pop_in(tx_pop),
		.data_out(tx_head),
		.empty_out(tx_empty),
		.full_out(tx_full)
	);

	ssp_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_rxq (
		.clock_in(clock_in),
		.rstn_in(rstn_in),
		.push_in(rx_push),
		.overwrite_in(rx_over),
		.data_in(rx_sh_r),
		.pop_in(rx_pop),
		.data_out(rx_head),
		.empty_out(rx_empty),
		.full_out(rx_full)
	);

	// Queue access from core and DMA; core write wins a shared cycle
	assign core_txw = bus_in.wr && (bus_in.addr == ssp_pkg::OFS_TXD);
	assign core_rxr = bus_in.rd && (bus_in.addr == ssp_pkg::OFS_RXD);
	// DMA fill goes through same queue
	assign dma_tx_ready_out = ctrl_r[ssp_pkg::CTRL_TXDMA] && !tx_full && !core_txw;
	assign tx_push = (core_txw && !tx_full) || (dma_tx_valid_in && dma_tx_ready_out);
	assign tx_wdata = core_txw ? bus_in.wdata : dma_tx_data_in;
	// DMA side drains on its own pace
	assign dma_rx_valid_out = ctrl_r[ssp_pkg::CTRL_RXDMA] && !rx_empty && !core_rxr;
	assign dma_rx_data_out = rx_head;
	assign rx_pop = (core_rxr && !rx_empty) || (dma_rx_valid_out && dma_rx_ready_in);

	// Shift engine: next state, bit count, divider, shifters, queue strobes
	always_comb
	begin
		st_nxt = st_r;
		div_nxt = div_r;
		bits_nxt = bits_r;
		tx_sh_nxt = tx_sh_r;
		rx_sh_nxt = rx_sh_r;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_over = 1'b0;
		ev = '0;
		unique case (st_r)
			ssp_pkg::ST_IDLE:
			begin
				if (ctrl_r[ssp_pkg::CTRL_EN] && !tx_empty)
				begin
					// length picks bit count and alignment
					bits_nxt = len_bits(ctrl_r[ssp_pkg::CTRL_LEN_LO +: 2]);
					tx_sh_nxt = tx_head << (6'h20 - bits_nxt);
					tx_pop = 1'b1;
					div_nxt = '0;
					st_nxt = ssp_pkg::ST_LOW;
				end
			end
			ssp_pkg::ST_LOW:
			begin
				if (div_r == HALF_LAST)
				begin
					// Sample on rising serial clock edge
					rx_sh_nxt = {rx_sh_r[W-2:0], miso};
					div_nxt = '0;
					st_nxt = ssp_pkg::ST_HIGH;
				end
				else
					div_nxt = div_r + 8'h01;
			end
			ssp_pkg::ST_HIGH:
			begin
				if (div_r != HALF_LAST)
					div_nxt = div_r + 8'h01;
				else if (bits_r != 6'h01)
				begin
					bits_nxt = bits_r - 6'h01;
					tx_sh_nxt = tx_sh_r << 1;
					div_nxt = '0;
					st_nxt = ssp_pkg::ST_LOW;
				end
				else
				begin
					bits_nxt = '0;
					ev[ssp_pkg::EV_TX_DONE] = 1'b1;
					st_nxt = ssp_pkg::ST_IDLE;
					if (!rx_full || rx_pop)
					begin
						rx_push = 1'b1;
						ev[ssp_pkg::EV_RX_WORD] = 1'b1;
						rx_sh_nxt = '0;
					end
					else
					begin
						ev[ssp_pkg::EV_OVERRUN] = 1'b1;
						if (ctrl_r[ssp_pkg::CTRL_STALL])
							st_nxt = ssp_pkg::ST_HOLD;
						else
						begin
							rx_push = ctrl_r[ssp_pkg::CTRL_KEEP_NEW];
							rx_over = ctrl_r[ssp_pkg::CTRL_KEEP_NEW];
							rx_sh_nxt = '0;
						end
					end
				end
			end
			ssp_pkg::ST_HOLD:
			begin
				// move held word once an entry frees
				if (!rx_full || rx_pop)
				begin
					rx_push = 1'b1;
					ev[ssp_pkg::EV_RX_WORD] = 1'b1;
					rx_sh_nxt = '0;
					st_nxt = ssp_pkg::ST_IDLE;
				end
			end
		endcase
		// Pin levels decoded ahead of a flop; a two-bit state step cannot glitch them
		sclk_nxt = (st_nxt == ssp_pkg::ST_HIGH);
		sel_n_nxt = (st_nxt == ssp_pkg::ST_IDLE);
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			st_r <= ssp_pkg::ST_IDLE;
			div_r <= '0;
			bits_r <= '0;
			tx_sh_r <= '0;
			rx_sh_r <= '0;
			sclk_r <= 1'b0;
			sel_n_r <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
			div_r <= div_nxt;
			bits_r <= bits_nxt;
			tx_sh_r <= tx_sh_nxt;
			rx_sh_r <= rx_sh_nxt;
			sclk_r <= sclk_nxt;
			sel_n_r <= sel_n_nxt;
		end
	end

	// Pins straight from flops; clock idles low between words and in hold
	assign serial_clock_out = sclk_r;
	assign serial_data_out = tx_sh_r[W-1];
	assign select_n_out = sel_n_r;

	// Register file: control, mask, sticky events (set beats clear), read data
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		imask_nxt = imask_r;
		istat_nxt = istat_r;
		rdata_nxt = '0;
		if (bus_in.wr)
		begin
			unique case (bus_in.addr)
				ssp_pkg::OFS_CTRL: ctrl_nxt = bus_in.wdata[ssp_pkg::CTRL_W-1:0];
				ssp_pkg::OFS_IMASK: imask_nxt = bus_in.wdata[3:0];
				ssp_pkg::OFS_ISTAT: istat_nxt = istat_r & ~bus_in.wdata[ssp_pkg::EV_W-1:0];
				default: ;
			endcase
		end
		istat_nxt = istat_nxt | ev;
		if (bus_in.rd)
		begin
			unique case (bus_in.addr)
				ssp_pkg::OFS_CTRL: rdata_nxt = 32'(ctrl_r);
				ssp_pkg::OFS_STAT:
				begin
					rdata_nxt[ssp_pkg::STAT_RX_LO +: 2] = fill(rx_empty, rx_full);
					// transmit fill from live queue state
					rdata_nxt[ssp_pkg::STAT_TX_LO +: 2] = fill(tx_empty, tx_full);
					rdata_nxt[ssp_pkg::STAT_OVR] = istat_r[ssp_pkg::EV_OVERRUN];
					rdata_nxt[ssp_pkg::STAT_BUSY] = (st_r != ssp_pkg::ST_IDLE);
					rdata_nxt[ssp_pkg::STAT_HOLD] = (st_r == ssp_pkg::ST_HOLD);
				end
				ssp_pkg::OFS_RXD: rdata_nxt = rx_head;
				ssp_pkg::OFS_ISTAT: rdata_nxt = {28'h0, !tx_full, istat_r};
				ssp_pkg::OFS_IMASK: rdata_nxt = {28'h0, imask_r};
				default: rdata_nxt = '0; // Unmapped reads as zero
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			ctrl_r <= ssp_pkg::CTRL_RST;
			imask_r <= ssp_pkg::IMASK_RST;
			istat_r <= '0;
			rdata_r <= '0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			imask_r <= imask_nxt;
			istat_r <= istat_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_out = rdata_r;
	// transmit room level request joins sticky events
	assign irq_out = |(istat_r & imask_r[ssp_pkg::EV_W-1:0])
		|| (imask_r[ssp_pkg::IRQ_TX_ROOM] && !tx_full);
endmodule // ssp_master
`default_nettype wire

// File: tb/ssp_slave_mdl.sv
// Behavioural serial slave facing the master port.
// Assumes data moves on the falling serial clock edge, MSB first.
`timescale 1ns/1ns
`default_nettype none
module ssp_slave_mdl (
	input wire logic sclk_in,
	input wire logic sel_n_in,
	input wire logic mosi_in,
	input wire logic [31:0] base_in,
	input wire logic [5:0] bits_in,
	output logic miso_out,
	output logic [31:0] got_out,
	output int frames_out
);
	logic [31:0] sh = 32'h0;
	logic [31:0] got_q = 32'h0;
	logic miso_q = 1'b0;
	logic sclk_q = 1'b0;
	logic sel_q = 1'b1;
	int cnt = 0;
	assign miso_out = miso_q;
	assign got_out = got_q;
	assign frames_out = cnt;
	// One process owns all state; edges found against the last levels seen
	always @(sclk_in or sel_n_in)
	begin
		if (sel_q && !sel_n_in)
		begin
			sh = (base_in + cnt) << (6'h20 - bits_in);
			cnt++;
			miso_q = sh[31];
			got_q = 32'h0;
		end
		else if (!sel_q && sel_n_in)
			// Released line shows the inverse, never a stale bit
			miso_q = ~miso_q;
		else if (sclk_q && !sclk_in && !sel_n_in)
		begin
			sh = sh << 1;
			miso_q = sh[31];
		end
		else if (!sclk_q && sclk_in)
			// Capture master data on the rise
			got_q = {got_q[30:0], mosi_in};
		sclk_q = sclk_in;
		sel_q = sel_n_in;
	end
endmodule // ssp_slave_mdl
`default_nettype wire

// File: tb/ssp_master_chk.sv
// Checker for the serial master port, watching its top ports only.
// Assumes the package register map and one core clock domain.
`timescale 1ns/1ns
`default_nettype none
module ssp_master_chk #(
	parameter int HALF_CYC = 8
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire ssp_pkg::ssp_bus_t bus_in,
	input wire logic [31:0] rdata_out,
	input wire logic dma_tx_valid_in,
	input wire logic dma_tx_ready_out,
	input wire logic dma_rx_valid_out,
	input wire logic dma_rx_ready_in,
	input wire logic serial_clock_out,
	input wire logic select_n_out,
	input wire logic irq_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	logic sclk_r, sclk_nxt;
	logic [5:0] rise_r, rise_nxt;
	logic [9:0] run_r, run_nxt;
	logic [3:0] imask_r, imask_nxt;
	// Run length saturates so long idle never wraps
	always_comb
	begin
		sclk_nxt = serial_clock_out;
		rise_nxt = select_n_out ? 6'h00 : rise_r + {5'h00, serial_clock_out & ~sclk_r};
		run_nxt = (serial_clock_out != sclk_r) ? 10'h001 : run_r + {9'h000, run_r != 10'h3FF};
		imask_nxt = imask_r;
		if (bus_in.wr && bus_in.addr == ssp_pkg::OFS_IMASK)
			imask_nxt = bus_in.wdata[3:0];
	end
	// Watch registers
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sclk_r <= 1'b0;
			rise_r <= 6'h00;
			run_r <= 10'h000;
			imask_r <= 4'h0;
		end
		else
		begin
			sclk_r <= sclk_nxt;
			rise_r <= rise_nxt;
			run_r <= run_nxt;
			imask_r <= imask_nxt;
		end
	end
	chk_idle_clock_low: assert property (
		select_n_out |-> !serial_clock_out) else $error("serial clock moved while idle");
	chk_high_half: assert property (
		sclk_r && !serial_clock_out |-> run_r == HALF_CYC) else $error("high half wrong");
	chk_low_half: assert property (
		!sclk_r && serial_clock_out |-> run_r >= HALF_CYC) else $error("low half short");
	chk_bit_count: assert property (
		$rose(select_n_out) |-> rise_r inside {6'h08, 6'h10, 6'h20}) else $error("bit count");
	chk_dma_tx_core: assert property (
		bus_in.wr && bus_in.addr == ssp_pkg::OFS_TXD |-> !dma_tx_ready_out) else $error("tx race");
	chk_dma_rx_core: assert property (
		bus_in.rd && bus_in.addr == ssp_pkg::OFS_RXD |-> !dma_rx_valid_out) else $error("rx race");
	chk_irq_masked: assert property (
		imask_r == 4'h0 |-> !irq_out) else $error("irq while masked");
	chk_fill_code: assert property (
		$past(bus_in.rd) && $past(bus_in.addr) == ssp_pkg::OFS_STAT
		|-> rdata_out[1:0] != 2'h2 && rdata_out[3:2] != 2'h2) else $error("bad fill code");
	cov_frame: cover property ($rose(select_n_out));
	cov_dma_tx: cover property (dma_tx_valid_in && dma_tx_ready_out);
	cov_dma_rx: cover property (dma_rx_valid_out && dma_rx_ready_in);
	cov_irq: cover property (irq_out);
endmodule // ssp_master_chk
bind ssp_master ssp_master_chk #(.HALF_CYC(HALF_CYC)) u_chk (.clock_in(clock_in),
	.rstn_in(rstn_in), .bus_in(bus_in), .rdata_out(rdata_out),
	.dma_tx_valid_in(dma_tx_valid_in), .dma_tx_ready_out(dma_tx_ready_out),
	.dma_rx_valid_out(dma_rx_valid_out), .dma_rx_ready_in(dma_rx_ready_in),
	.serial_clock_out(serial_clock_out), .select_n_out(select_n_out), .irq_out(irq_out));
`default_nettype wire

// File: tb/serial_master_rx_tx_buffering_tb.sv
// Bench for the serial master port: register, DMA and serial link scenarios.
// Assumes the slave model and checker are compiled ahead of it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module serial_master_rx_tx_buffering_tb;
	localparam logic [7:0] CT = ssp_pkg::OFS_CTRL;
	localparam logic [7:0] ST = ssp_pkg::OFS_STAT;
	localparam logic [7:0] TX = ssp_pkg::OFS_TXD;
	localparam logic [7:0] RX = ssp_pkg::OFS_RXD;
	localparam logic [7:0] IS = ssp_pkg::OFS_ISTAT;
	localparam logic [7:0] IM = ssp_pkg::OFS_IMASK;
	logic clock_in = 1'b0;
	logic rstn_in = 1'b0;
	ssp_pkg::ssp_bus_t bus = '0;
	logic [31:0] rdata, drx_d, got, dtx_d = '0, base = 32'hA5;
	logic dtx_v = 1'b0, drx_r = 1'b0;
	logic dtx_r, drx_v, miso, sclk, mosi, sel_n, irq;
	logic [5:0] bits = 6'h08;
	int frames, f0;
	int bad_count = 0;
	int n_tests = 0;
	logic [31:0] q[$];
	always #5 clock_in = ~clock_in;
	ssp_master u_dut (.clock_in(clock_in), .rstn_in(rstn_in), .bus_in(bus), .rdata_out(rdata),
		.dma_tx_valid_in(dtx_v), .dma_tx_data_in(dtx_d), .dma_tx_ready_out(dtx_r),
		.dma_rx_valid_out(drx_v), .dma_rx_data_out(drx_d), .dma_rx_ready_in(drx_r),
		.serial_data_in(miso), .serial_clock_out(sclk), .serial_data_out(mosi),
		.select_n_out(sel_n), .irq_out(irq));
	ssp_slave_mdl u_slv (.sclk_in(sclk), .sel_n_in(sel_n), .mosi_in(mosi), .base_in(base),
		.bits_in(bits), .miso_out(miso), .got_out(got), .frames_out(frames));
	always @(negedge clock_in)
		if (drx_v && drx_r)
			q.push_back(drx_d);
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clock_in) bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n,
		input logic [31:0] m = '1);
		@(posedge clock_in) bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clock_in) bus.rd <= 1'b0;
		#1 `CHK(n, e, rdata & m)
	endtask
	// Holds valid until ready is seen at an edge
	task automatic dpush(input logic [31:0] d);
		@(posedge clock_in) {dtx_v, dtx_d} <= {1'b1, d};
		@(negedge clock_in);
		for (int i = 0; i < 50 && dtx_r !== 1'b1; i++)
			@(negedge clock_in);
		// A ready that never comes counts as a mismatch
		if (dtx_r !== 1'b1)
			bad_count++;
		@(posedge clock_in) dtx_v <= 1'b0;
	endtask
	function automatic logic [31:0] ex(input int j);
		logic [63:0] m;
		m = (64'h1 << bits) - 64'h1;
		return (base + f0 + j) & m[31:0];
	endfunction
	task automatic go(input logic [31:0] c);
		wr(CT, c);
		f0 = frames;
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Cuts a hang short; the tests need about 30 us
	initial
	begin
		#300000;
		bad_count++;
		give_verdict();
	end
	initial
	begin
		repeat (5) @(posedge clock_in);
		rstn_in <= 1'b1;
		rd(CT, 32'h40, "ctrl reset");
		rd(IS, 32'h8, "istat reset");
		rd(ST, 32'h0, "stat reset");
		rd(8'h18, 32'h0, "unmapped");
		$display("Test reset done");
		wr(IM, 32'h8);
		wr(TX, 32'h11);
		rd(ST, 32'h4, "tx partial");
		wr(TX, 32'h22);
		wr(TX, 32'h33);
		rd(ST, 32'hC, "tx full");
		`CHK("irq full", 1'b0, irq)
		go(32'h41);
		repeat (300) @(posedge clock_in);
		rd(ST, 32'h3, "rx full", 32'h5F);
		rd(IS, 32'hD, "istat words");
		`CHK("irq room", 1'b1, irq)
		`CHK("mosi word", 32'h22, got)
		wr(IM, 32'h1);
		#1 `CHK("irq rx", 1'b1, irq)
		wr(IS, 32'h1);
		#1 `CHK("irq clear", 1'b0, irq)
		$display("Test fill done");
		wr(TX, 32'h44);
		repeat (200) @(posedge clock_in);
		rd(ST, 32'h53, "hold", 32'h5F);
		`CHK("stall pins", 2'b00, {sclk, sel_n})
		rd(RX, ex(0), "pop");
		repeat (20) @(posedge clock_in);
		rd(RX, ex(1), "queued");
		rd(RX, ex(2), "held");
		rd(ST, 32'h10, "rx empty", 32'h53);
		wr(IS, 32'h2);
		rd(ST, 32'h0, "ovr clear", 32'h10);
		$display("Test stall done");
		for (int k = 0; k < 2; k++)
		begin
			go({30'h0, k[0], 1'b1});
			repeat (3) wr(TX, 32'h5A);
			repeat (450) @(posedge clock_in);
			rd(RX, ex(0), "first");
			rd(RX, ex(k ? 2 : 1), "second");
			rd(IS, 32'hA, "overrun", 32'hA);
			wr(IS, 32'h7);
		end
		$display("Test overrun done");
		for (int l = 1; l < 3; l++)
		begin
			bits = (l == 1) ? 6'h10 : 6'h20;
			go({28'h0, l[1:0], 2'h1});
			wr(TX, 32'hC3A596F0);
			repeat (600) @(posedge clock_in);
			rd(RX, ex(0), "long rx");
			`CHK("long tx", (l == 1) ? 32'h000096F0 : 32'hC3A596F0, got)
		end
		$display("Test length done");
		bits = 6'h08;
		go(32'h10);
		dpush(32'h81);
		rd(ST, 32'h4, "dma partial", 32'hC);
		dpush(32'h82);
		rd(ST, 32'hC, "dma full", 32'hC);
		`CHK("dma ready", 1'b0, dtx_r)
		@(posedge clock_in) drx_r <= 1'b1;
		go(32'h31);
		repeat (300) @(posedge clock_in);
		`CHK("dma count", 2, q.size())
		`CHK("dma rx0", ex(0), q[0])
		`CHK("dma rx1", ex(1), q[1])
		`CHK("dma tx", 32'h82, got)
		$display("Test dma done");
		give_verdict();
	end
endmodule // serial_master_rx_tx_buffering_tb
`default_nettype wire
